// File: dspic_ctrl.sv
// Interrupt controller core with AXI4-Lite registers and status stack.
// Assumes pins pass through on-chip synchronisers here; sequencer on sys_clk_in.
`timescale 1ns/10ps
`include "dspic_consts.svh"
module dspic_ctrl
  import dspic_pkg::*;
#(
  parameter int STACK_DEPTH = `DSPIC_STACK_DEPTH
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // AXI4-Lite slave
  input wire logic [31:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [31:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // External request pins, active low
  input wire logic ext_request_two_n_in,
  input wire logic level_request_one_n_in,
  input wire logic level_request_zero_n_in,
  input wire logic edge_only_request_n_in,
  input wire logic ext_request_one_n_in,
  input wire logic ext_request_zero_n_in,
  // Flag outputs on the shared pins, active low level
  input wire logic [3:0] shared_flag_out_n_in,
  input wire logic [3:0] shared_flag_oe_in,
  // Internal sources, one-cycle pulses
  input wire logic powerdown_req_in,
  input wire logic serial0_tx_in,
  input wire logic serial0_rx_in,
  input wire logic dma_done_in,
  input wire logic serial1_tx_in,
  input wire logic serial1_rx_in,
  input wire logic timer_in,
  input wire logic powerup_in,
  // Sequencer handshake
  input wire logic vec_ack_in,
  input wire logic rti_in,
  input wire logic [15:0] status_word_in,
  output logic vec_valid_out,
  output logic [15:0] vec_addr_out,
  output logic [15:0] status_pop_out,
  output logic stack_overflow_out,
  // Host interrupt
  output logic irq_out
);
  // ==========================================================
  // Pin synchronisers
  localparam int NP = 10;
  logic [NP-1:0] pin_raw, sync1_q, sync2_q, prev_q;
  logic [3:0] flag_lvl;
  assign flag_lvl = (shared_flag_oe_in & ~shared_flag_out_n_in);
  assign pin_raw = {~ext_request_zero_n_in, ~ext_request_one_n_in,
    ~edge_only_request_n_in, ~level_request_zero_n_in,
    ~level_request_one_n_in, ~ext_request_two_n_in, flag_lvl};
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q <= '0;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end
  // Pin asserted by outside device, or by own flag drive on x2, l1, l0 and xe only
  logic x2, l1, l0, xe, x1, x0;
  assign x2 = sync2_q[4] | sync2_q[3];
  assign l1 = sync2_q[5] | sync2_q[2];
  assign l0 = sync2_q[6] | sync2_q[1];
  assign xe = sync2_q[7] | sync2_q[0];
  assign x1 = sync2_q[8];
  assign x0 = sync2_q[9];
  logic x2p, xep, x1p, x0p;
  assign x2p = prev_q[4] | prev_q[3];
  assign xep = prev_q[7] | prev_q[0];
  assign x1p = prev_q[8];
  assign x0p = prev_q[9];

  // ==========================================================
  // Registers and pending state
  logic [10:0] mask_q, mask_d;
  logic [4:0] ctrl_q, ctrl_d;
  logic [2:0] sys_q, sys_d;
  dspic_src_t edge_q, edge_d, stat_q, stat_d, irqm_q, irqm_d;
  logic hold_q, hold_d;
  logic [3:0] nest_q, nest_d;
  dspic_src_t pend, act;
  logic [3:0] win;
  logic any_win;
  dspic_src_t sw_set, sw_clr, svc, edge_ev, lvl;
  logic wr_fire, rd_fire;
  dspic_wreq_t wreq;
  logic [7:0] waddr, raddr;
  assign waddr = wreq.addr[7:0];
  assign raddr = s_axi_araddr_in[7:0];
  logic s1_irq;
  assign s1_irq = sys_q[`DSPIC_SYS_S1IRQ];

  always_comb begin
    edge_ev = '0;
    lvl = '0;
    edge_ev[`DSPIC_B_PWD] = powerdown_req_in;
    edge_ev[`DSPIC_B_S0T] = serial0_tx_in;
    edge_ev[`DSPIC_B_S0R] = serial0_rx_in;
    edge_ev[`DSPIC_B_DMA] = dma_done_in;
    edge_ev[`DSPIC_B_TMR] = timer_in;
    edge_ev[`DSPIC_B_XE] = xe & ~xep;
    if (ctrl_q[`DSPIC_CTL_X2_EDGE]) edge_ev[`DSPIC_B_X2] = x2 & ~x2p;
    else lvl[`DSPIC_B_X2] = x2;
    lvl[`DSPIC_B_L1] = l1;
    lvl[`DSPIC_B_L0] = l0;
    if (s1_irq) begin
      if (ctrl_q[`DSPIC_CTL_X1_EDGE]) edge_ev[`DSPIC_B_S1T] = x1 & ~x1p;
      else lvl[`DSPIC_B_S1T] = x1;
      if (ctrl_q[`DSPIC_CTL_X0_EDGE]) edge_ev[`DSPIC_B_S1R] = x0 & ~x0p;
      else lvl[`DSPIC_B_S1R] = x0;
    end else begin
      edge_ev[`DSPIC_B_S1T] = serial1_tx_in;
      edge_ev[`DSPIC_B_S1R] = serial1_rx_in;
    end
  end

  // Priority select: lowest bit wins
  assign pend = edge_q | lvl;
  assign act = pend & (mask_q | dspic_src_t'(1));
  always_comb begin
    win = 4'h0;
    any_win = 1'b0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (act[i]) begin
        win = 4'(i);
        any_win = 1'b1;
      end
    end
  end
  // Nesting: only higher than current level, or none active
  logic take;
  logic [3:0] cur_q, cur_d;
  logic [3:0] lvl_stk_q [STACK_DEPTH];
  logic [15:0] stk_q [STACK_DEPTH];
  logic [3:0] sp_q, sp_d;
  logic nest_ok;
  assign nest_ok = (nest_q == 4'h0) ||
    (ctrl_q[`DSPIC_CTL_NEST] && win < cur_q);
  assign take = any_win && !hold_q && sys_q[`DSPIC_SYS_GIE] && nest_ok
    && !powerup_in;
  assign vec_valid_out = take | powerup_in;
  always_comb begin
    if (powerup_in && sys_q[`DSPIC_SYS_PUC]) vec_addr_out = `DSPIC_VEC_RESET;
    else vec_addr_out = dspic_vec(int'(win));
  end
  always_comb begin
    svc = '0;
    if (take && vec_ack_in) svc[win] = 1'b1;
  end

  // ==========================================================
  // Register state
  always_comb begin
    mask_d = mask_q;
    ctrl_d = ctrl_q;
    sys_d = sys_q;
    hold_d = 1'b0;
    sw_set = '0;
    sw_clr = '0;
    if (wr_fire) begin
      case (waddr)
        `DSPIC_MASK_OFS: begin
          mask_d = wreq.wdata[10:0];
          hold_d = 1'b1;
        end
        `DSPIC_CTRL_OFS: ctrl_d = wreq.wdata[4:0];
        `DSPIC_FC_OFS: begin
          sw_set = wreq.wdata[10:0];
          sw_clr = wreq.wdata[`DSPIC_FC_CLR_LSB +: 11];
        end
        `DSPIC_IRQM_OFS: ;
        `DSPIC_SYS_OFS: sys_d = wreq.wdata[2:0];
        default: ;
      endcase
    end
    // New events win over software clear and service
    edge_d = (edge_q & ~sw_clr & ~svc) | sw_set | edge_ev;
    stat_d = (rd_fire && raddr == `DSPIC_STAT_OFS) ? svc : (stat_q | svc);
    irqm_d = irqm_q;
    if (wr_fire && waddr == `DSPIC_IRQM_OFS) irqm_d = wreq.wdata[10:0];
  end
  assign irq_out = |(stat_q & irqm_q);

  // ==========================================================
  // Status stack
  assign stack_overflow_out = (sp_q == 4'(STACK_DEPTH)) && take && vec_ack_in;
  always_comb begin
    sp_d = sp_q;
    cur_d = cur_q;
    nest_d = nest_q;
    if (take && vec_ack_in && sp_q != 4'(STACK_DEPTH)) begin
      sp_d = sp_q + 4'h1;
      cur_d = win;
      nest_d = nest_q + 4'h1;
    end else if (rti_in && sp_q != 4'h0) begin
      sp_d = sp_q - 4'h1;
      cur_d = (sp_q == 4'h1) ? 4'hf : lvl_stk_q[sp_q - 4'h1];
      nest_d = (nest_q == 4'h0) ? 4'h0 : nest_q - 4'h1;
    end
  end
  assign status_pop_out = (sp_q == 4'h0) ? 16'h0000 : stk_q[sp_q - 4'h1];
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sp_q <= 4'h0;
      cur_q <= 4'hf;
      nest_q <= 4'h0;
    end else begin
      sp_q <= sp_d;
      cur_q <= cur_d;
      nest_q <= nest_d;
    end
  end
  always_ff @(posedge sys_clk_in) begin
    if (take && vec_ack_in && sp_q != 4'(STACK_DEPTH)) begin
      stk_q[sp_q] <= status_word_in;
      lvl_stk_q[sp_q] <= cur_q;
    end
  end
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mask_q <= `DSPIC_MASK_RST;
      ctrl_q <= `DSPIC_CTRL_RST;
      sys_q <= `DSPIC_SYS_RST;
      edge_q <= '0;
      stat_q <= '0;
      irqm_q <= '0;
      hold_q <= 1'b0;
    end else begin
      mask_q <= mask_d;
      ctrl_q <= ctrl_d;
      sys_q <= sys_d;
      edge_q <= edge_d;
      stat_q <= stat_d;
      irqm_q <= irqm_d;
      hold_q <= hold_d;
    end
  end

  // ==========================================================
  // AXI4-Lite slave
  dspic_bus_st_t st_q, st_d;
  logic aw_q, aw_d, w_q, w_d;
  dspic_wreq_t wreq_q, wreq_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] resp_q, resp_d;
  assign s_axi_awready_out = (st_q == DSPIC_IDLE) && !aw_q;
  assign s_axi_wready_out = (st_q == DSPIC_IDLE) && !w_q;
  assign s_axi_arready_out = (st_q == DSPIC_IDLE) && !aw_q && !w_q
    && !s_axi_awvalid_in && !s_axi_wvalid_in;
  assign s_axi_bvalid_out = (st_q == DSPIC_WRSP);
  assign s_axi_rvalid_out = (st_q == DSPIC_RRSP);
  assign s_axi_bresp_out = resp_q;
  assign s_axi_rresp_out = resp_q;
  assign s_axi_rdata_out = rdata_q;
  assign wreq = wreq_q;
  assign wr_fire = (st_q == DSPIC_IDLE) && aw_q && w_q;
  assign rd_fire = s_axi_arvalid_in && s_axi_arready_out;
  function automatic logic mapped(input logic [7:0] a);
    return a <= `DSPIC_SYS_OFS && a[1:0] == 2'b00;
  endfunction : mapped
  always_comb begin
    st_d = st_q;
    aw_d = aw_q;
    w_d = w_q;
    wreq_d = wreq_q;
    rdata_d = rdata_q;
    resp_d = resp_q;
    case (st_q)
      DSPIC_IDLE: begin
        if (s_axi_awvalid_in && s_axi_awready_out) begin
          aw_d = 1'b1;
          wreq_d.addr = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && s_axi_wready_out) begin
          w_d = 1'b1;
          wreq_d.wdata = s_axi_wdata_in;
          wreq_d.wstrb = s_axi_wstrb_in;
        end
        if (wr_fire) begin
          aw_d = 1'b0;
          w_d = 1'b0;
          resp_d = mapped(waddr) ? 2'b00 : 2'b10;
          st_d = DSPIC_WRSP;
        end else if (rd_fire) begin
          resp_d = mapped(raddr) ? 2'b00 : 2'b10;
          case (raddr)
            `DSPIC_MASK_OFS: rdata_d = {21'h0, mask_q};
            `DSPIC_CTRL_OFS: rdata_d = {27'h0, ctrl_q};
            `DSPIC_STAT_OFS: rdata_d = {21'h0, stat_q};
            `DSPIC_PEND_OFS: rdata_d = {21'h0, pend};
            `DSPIC_IRQM_OFS: rdata_d = {21'h0, irqm_q};
            `DSPIC_VEC_OFS: rdata_d = {12'h0, cur_q, 16'h0000} | {16'h0, vec_addr_out};
            `DSPIC_SYS_OFS: rdata_d = {29'h0, sys_q};
            default: rdata_d = 32'h0000_0000;
          endcase
          st_d = DSPIC_RRSP;
        end
      end
      DSPIC_WRSP: if (s_axi_bready_in) st_d = DSPIC_IDLE;
      DSPIC_RRSP: if (s_axi_rready_in) st_d = DSPIC_IDLE;
      default: st_d = DSPIC_IDLE;
    endcase
  end
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_q <= DSPIC_IDLE;
      aw_q <= 1'b0;
      w_q <= 1'b0;
      wreq_q <= '0;
      rdata_q <= 32'h0000_0000;
      resp_q <= 2'b00;
    end else begin
      st_q <= st_d;
      aw_q <= aw_d;
      w_q <= w_d;
      wreq_q <= wreq_d;
      rdata_q <= rdata_d;
      resp_q <= resp_d;
    end
  end

  // ==========================================================
  // Assertions
  mask_hold_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (wr_fire && waddr == `DSPIC_MASK_OFS) |=> !take)
    else $error("interrupt taken right after mask write");
  glob_gate_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    !sys_q[`DSPIC_SYS_GIE] |-> !take)
    else $error("interrupt taken while globally disabled");
  pwd_vec_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (take && act[`DSPIC_B_PWD]) |-> vec_addr_out == 16'h002c)
    else $error("power-down not vectored to 002c");
  mask_gate_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    take |-> (mask_q[win] || win == 4'h0))
    else $error("masked source selected");
  reset_vec_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (powerup_in && sys_q[`DSPIC_SYS_PUC]) |-> vec_addr_out == 16'h0000 && vec_valid_out)
    else $error("power-up not vectored to 0000");
  edge_latch_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (edge_ev[`DSPIC_B_XE]) |=> edge_q[`DSPIC_B_XE])
    else $error("edge request not latched");
  stack_push_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (take && vec_ack_in && sp_q < 4'(STACK_DEPTH)) |=> sp_q == $past(sp_q) + 4'h1)
    else $error("status not pushed");
  level_track_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    pend[`DSPIC_B_L0] == (l0 | edge_q[`DSPIC_B_L0]))
    else $error("level request zero mis-tracked");
  fc_read_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (rd_fire && raddr == `DSPIC_FC_OFS) |=> s_axi_rdata_out == 32'h0)
    else $error("force/clear read not zero");
endmodule : dspic_ctrl

// File: dspic_consts.svh
// Constants of the prioritising interrupt controller.
// Assumes inclusion by the package, the design file and the testbench.
//
// Summary of operation
// - Reset or power-up context wins, vector 0000
// - Power-down unmaskable, vector 002C, below reset
// - External two 0004, level one 0008, zero 000C, edge 0018
// - Serial0 tx 0010, rx 0014, DMA 001C, timer 0028
// - Vector 0020: serial1 transmit or external one
// - Vector 0024: serial1 receive or external zero
// - Pending ANDed with mask, highest wins
// - Mask write holds off interrupts one cycle
// - Control selects nesting and edge/level sensing
// - Level zero/one level, edge-only always edge
// - Software can set or clear edge-only pending
// - Write-only force/clear register, reads zero
// - Twelve-deep status stack on entry and return
// - Shared flag pins interrupt when driven low
// - Serial1 reconfigurable as external zero and one
// - Global enable gates all but power-up, including power-down
// - Global enable set after reset
`ifndef DSPIC_CONSTS_SVH
`define DSPIC_CONSTS_SVH
// Register byte offsets
`define DSPIC_MASK_OFS 8'h00
`define DSPIC_CTRL_OFS 8'h04
`define DSPIC_FC_OFS 8'h08
`define DSPIC_STAT_OFS 8'h0c
`define DSPIC_PEND_OFS 8'h10
`define DSPIC_IRQM_OFS 8'h14
`define DSPIC_VEC_OFS 8'h18
`define DSPIC_SYS_OFS 8'h1c
// Source bit positions, priority order
`define DSPIC_B_PWD 0
`define DSPIC_B_X2 1
`define DSPIC_B_L1 2
`define DSPIC_B_L0 3
`define DSPIC_B_S0T 4
`define DSPIC_B_S0R 5
`define DSPIC_B_XE 6
`define DSPIC_B_DMA 7
`define DSPIC_B_S1T 8
`define DSPIC_B_S1R 9
`define DSPIC_B_TMR 10
// Control register fields
`define DSPIC_CTL_X0_EDGE 0
`define DSPIC_CTL_X1_EDGE 1
`define DSPIC_CTL_X2_EDGE 2
`define DSPIC_CTL_NEST 4
// Force/clear layout: set in [10:0], clear in [26:16]
`define DSPIC_FC_CLR_LSB 16
// Global enable bit of the system register, serial1 reconfig bit
`define DSPIC_SYS_GIE 0
`define DSPIC_SYS_S1IRQ 1
`define DSPIC_SYS_PUC 2
// Reset values
`define DSPIC_MASK_RST 11'h000
`define DSPIC_CTRL_RST 5'h00
`define DSPIC_SYS_RST 3'h1
`define DSPIC_STACK_DEPTH 12
`define DSPIC_VEC_RESET 16'h0000
`endif

// File: dspic_pkg.sv
// Types of the prioritising interrupt controller.
// Assumes the constants header beside it.
`include "dspic_consts.svh"
package dspic_pkg;
  localparam int NSRC = 11;
  typedef logic [NSRC-1:0] dspic_src_t;
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
  } dspic_wreq_t;
  typedef enum logic [2:0] {
    DSPIC_IDLE = 3'b001,
    DSPIC_WRSP = 3'b010,
    DSPIC_RRSP = 3'b100
  } dspic_bus_st_t;
  // Vector per source bit
  function automatic logic [15:0] dspic_vec(input int i);
    case (i)
      0: return 16'h002c;
      1: return 16'h0004;
      2: return 16'h0008;
      3: return 16'h000c;
      4: return 16'h0010;
      5: return 16'h0014;
      6: return 16'h0018;
      7: return 16'h001c;
      8: return 16'h0020;
      9: return 16'h0024;
      default: return 16'h0028;
    endcase
  endfunction : dspic_vec
endpackage : dspic_pkg

// File: dspic_seq_model.sv
// Sequencer model: takes offered vectors and supplies status words.
// Assumes the controller on the same clock and reset.
`timescale 1ns/10ps
module dspic_seq_model (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // Controller side
  input wire logic vec_valid_in,
  input wire logic [15:0] vec_addr_in,
  output logic vec_ack_out,
  output logic [15:0] status_word_out,
  output logic [15:0] taken_vec_out,
  // Test control
  input wire logic ack_en_in,
  input wire logic [3:0] ack_delay_in
);
  logic [3:0] wait_q;
  // ==========================================
  // Ack after a programmable wait
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      vec_ack_out <= 1'h0;
      wait_q <= 4'h0;
      status_word_out <= 16'h5a00;
      taken_vec_out <= 16'hffff;
    end else if (vec_ack_out) begin
      vec_ack_out <= 1'h0;
      wait_q <= 4'h0;
      taken_vec_out <= vec_addr_in;
      status_word_out <= status_word_out + 16'h0001;
    end else if (vec_valid_in && ack_en_in) begin
      if (wait_q == ack_delay_in) begin
        vec_ack_out <= 1'h1;
      end else begin
        wait_q <= wait_q + 4'h1;
      end
    end else begin
      wait_q <= 4'h0;
    end
  end
endmodule : dspic_seq_model

// File: dspic_ctrl_tb.sv
// Testbench of the interrupt controller: bus tasks and sequences.
// Assumes the design and the sequencer model compiled first.
`timescale 1ns/10ps
`include "dspic_consts.svh"
module dspic_ctrl_tb;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, vvalid, ack, irq, ovf;
  logic [1:0] bresp, rresp;
  logic x2_n = 1'h1, l1_n = 1'h1, l0_n = 1'h1, xe_n = 1'h1, x1_n = 1'h1, x0_n = 1'h1;
  logic [3:0] flag_n = 4'hf, flag_oe = 4'h0, ack_dly = 4'h0;
  logic [6:0] src = 7'h00;
  logic pup = 1'h0, rti = 1'h0, ack_en = 1'h0;
  logic [15:0] vaddr, sword, taken, pop;
  int bad_count = 0;
  int tests_run = 0;
  logic [15:0] vecs [11] = '{16'h002c, 16'h0004, 16'h0008, 16'h000c, 16'h0010, 16'h0014,
    16'h0018, 16'h001c, 16'h0020, 16'h0024, 16'h0028};
  int pbit [7] = '{0, 4, 5, 7, 8, 9, 10};

  always #25 clk = ~clk;

  dspic_ctrl #(.STACK_DEPTH(12)) u_dut (
    .sys_clk_in(clk), .resetn_in(rst_n),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .ext_request_two_n_in(x2_n), .level_request_one_n_in(l1_n),
    .level_request_zero_n_in(l0_n), .edge_only_request_n_in(xe_n),
    .ext_request_one_n_in(x1_n), .ext_request_zero_n_in(x0_n),
    .shared_flag_out_n_in(flag_n), .shared_flag_oe_in(flag_oe),
    .powerdown_req_in(src[0]), .serial0_tx_in(src[1]), .serial0_rx_in(src[2]),
    .dma_done_in(src[3]), .serial1_tx_in(src[4]), .serial1_rx_in(src[5]),
    .timer_in(src[6]), .powerup_in(pup), .vec_ack_in(ack), .rti_in(rti),
    .status_word_in(sword), .vec_valid_out(vvalid), .vec_addr_out(vaddr),
    .status_pop_out(pop), .stack_overflow_out(ovf), .irq_out(irq));

  dspic_seq_model u_seq (
    .sys_clk_in(clk), .resetn_in(rst_n), .vec_valid_in(vvalid), .vec_addr_in(vaddr),
    .vec_ack_out(ack), .status_word_out(sword), .taken_vec_out(taken),
    .ack_en_in(ack_en), .ack_delay_in(ack_dly));

  // ==========================================
  // Compare, bus and stimulus tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD time=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= {24'h000000, a};
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      n++;
    end while (bvalid !== 1'h1 && n < 50);
    if (bvalid !== 1'h1) bad_count++;
    bready <= 1'h0;
    chk({30'h0, bresp}, 32'h0);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= {24'h000000, a};
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'h0;
      n++;
    end while (rvalid !== 1'h1 && n < 50);
    if (rvalid !== 1'h1) bad_count++;
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask : rd

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, e);
  endtask : rdchk

  task automatic pulse(input int i);
    src <= 7'(1 << i);
    @(posedge clk);
    src <= 7'h00;
  endtask : pulse

  task automatic handler(input logic [15:0] e);
    for (int k = 0; k < 60 && sword !== e; k++) @(posedge clk);
    chk(sword, e);
    chk(taken, 16'h0028);
    chk(pop, e - 16'h0001);
    tick(2);
  endtask : handler

  task automatic summarize;
    $display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize

  // ==========================================
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    summarize();
  end

  // ==========================================
  // Test sequence
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    tick(4);
    rst_n <= 1'h1;
    rdchk(`DSPIC_MASK_OFS, 32'h0);
    rdchk(`DSPIC_CTRL_OFS, 32'h0);
    rdchk(`DSPIC_SYS_OFS, 32'h1);
    rdchk(`DSPIC_FC_OFS, 32'h0);
    rd(8'h20, d, r);
    chk({d[31:2], r}, 32'h2);
    // Priority walk with every source pending
    wr(`DSPIC_CTRL_OFS, 32'h4);
    wr(`DSPIC_MASK_OFS, 32'h7ff);
    l1_n <= 1'h0;
    l0_n <= 1'h0;
    wr(`DSPIC_FC_OFS, 32'h7f3);
    for (int i = 0; i < 11; i++) begin
      chk(vvalid, 32'h1);
      chk(vaddr, vecs[i]);
      if (i == 2) l1_n <= 1'h1;
      if (i == 3) l0_n <= 1'h1;
      if (i == 2 || i == 3) tick(4);
      else wr(`DSPIC_FC_OFS, 32'h1 << (16 + i));
    end
    // Internal sources latch
    wr(`DSPIC_MASK_OFS, 32'h0);
    for (int i = 0; i < 7; i++) begin
      pulse(i);
      rdchk(`DSPIC_PEND_OFS, 32'h1 << pbit[i]);
      wr(`DSPIC_FC_OFS, 32'h07ff0000);
    end
    wr(`DSPIC_FC_OFS, 32'h400);
    chk(vvalid, 32'h0);
    wr(`DSPIC_FC_OFS, 32'h1);
    chk(vaddr, 16'h002c);
    wr(`DSPIC_SYS_OFS, 32'h0);
    chk(vvalid, 32'h0);
    wr(`DSPIC_SYS_OFS, 32'h1);
    wr(`DSPIC_FC_OFS, 32'h07ff0000);
    // Pin sensing
    wr(`DSPIC_CTRL_OFS, 32'h7);
    xe_n <= 1'h0;
    tick(2);
    xe_n <= 1'h1;
    tick(4);
    rdchk(`DSPIC_PEND_OFS, 32'h40);
    wr(`DSPIC_FC_OFS, 32'h00400000);
    rdchk(`DSPIC_PEND_OFS, 32'h0);
    wr(`DSPIC_FC_OFS, 32'h40);
    rdchk(`DSPIC_PEND_OFS, 32'h40);
    wr(`DSPIC_FC_OFS, 32'h00400000);
    l1_n <= 1'h0;
    tick(4);
    rdchk(`DSPIC_PEND_OFS, 32'h4);
    l1_n <= 1'h1;
    tick(4);
    rdchk(`DSPIC_PEND_OFS, 32'h0);
    x2_n <= 1'h0;
    tick(2);
    x2_n <= 1'h1;
    tick(4);
    rdchk(`DSPIC_PEND_OFS, 32'h2);
    wr(`DSPIC_CTRL_OFS, 32'h0);
    wr(`DSPIC_FC_OFS, 32'h00020000);
    flag_oe <= 4'h8;
    flag_n <= 4'h7;
    tick(4);
    rdchk(`DSPIC_PEND_OFS, 32'h2);
    flag_n <= 4'hf;
    flag_oe <= 4'h0;
    tick(4);
    rdchk(`DSPIC_PEND_OFS, 32'h0);
    // Second serial port pins as requests
    wr(`DSPIC_SYS_OFS, 32'h3);
    x1_n <= 1'h0;
    tick(4);
    rdchk(`DSPIC_PEND_OFS, 32'h100);
    wr(`DSPIC_MASK_OFS, 32'h100);
    tick(2);
    chk(vaddr, 16'h0020);
    x1_n <= 1'h1;
    x0_n <= 1'h0;
    tick(4);
    wr(`DSPIC_MASK_OFS, 32'h200);
    tick(2);
    chk(vaddr, 16'h0024);
    x0_n <= 1'h1;
    wr(`DSPIC_SYS_OFS, 32'h5);
    pup <= 1'h1;
    tick(2);
    chk(vvalid, 32'h1);
    chk(vaddr, 16'h0000);
    pup <= 1'h0;
    wr(`DSPIC_SYS_OFS, 32'h1);
    // Serviced handlers, stack and host interrupt
    wr(`DSPIC_MASK_OFS, 32'h400);
    wr(`DSPIC_IRQM_OFS, 32'h400);
    ack_en <= 1'h1;
    pulse(6);
    handler(16'h5a01);
    chk(irq, 32'h1);
    rdchk(`DSPIC_STAT_OFS, 32'h400);
    tick(2);
    chk(irq, 32'h0);
    rti <= 1'h1;
    tick(1);
    rti <= 1'h0;
    wr(`DSPIC_IRQM_OFS, 32'h0);
    ack_dly <= 4'h5;
    pulse(6);
    handler(16'h5a02);
    chk(irq, 32'h0);
    rdchk(`DSPIC_STAT_OFS, 32'h400);
    rti <= 1'h1;
    tick(1);
    rti <= 1'h0;
    tick(2);
    // Sequential then nested servicing
    wr(`DSPIC_MASK_OFS, 32'h480);
    ack_dly <= 4'h0;
    pulse(6);
    tick(6);
    pulse(3);
    tick(6);
    chk(vvalid, 32'h0);
    chk(taken, 16'h0028);
    wr(`DSPIC_CTRL_OFS, 32'h10);
    tick(6);
    chk(taken, 16'h001c);
    chk(pop, 16'h5a03);
    chk(ovf, 32'h0);
    rti <= 1'h1;
    tick(2);
    rti <= 1'h0;
    tick(2);
    summarize();
  end
endmodule : dspic_ctrl_tb
